/* hdl/sstp_defines.svh */
`ifndef SSTP_DEFINES_SVH
`define SSTP_DEFINES_SVH

// Register byte offsets on the Wishbone slave
`define SSTP_ADR_W           5
`define SSTP_OFF_CTRL        5'h00
`define SSTP_OFF_TELE        5'h04
`define SSTP_OFF_CRC         5'h08
`define SSTP_OFF_CMD         5'h0c
`define SSTP_OFF_IRQ_STAT    5'h10
`define SSTP_OFF_IRQ_MASK    5'h14

// Control register fields
`define SSTP_CTRL_MODE_LSB   0
`define SSTP_CTRL_MODE_MSB   2
`define SSTP_CTRL_RST        3'h0

// Interrupt bits, shared by status and mask
`define SSTP_IRQ_W           4
`define SSTP_IRQ_TELE        0
`define SSTP_IRQ_CMD         1
`define SSTP_IRQ_SAFE_FALL   2
`define SSTP_IRQ_RSV_ERR     3
`define SSTP_IRQ_MASK_RST    4'h0

// Input telegram bit positions
`define SSTP_B0_SAFE_LSB     0
`define SSTP_B0_STATE_LSB    4
`define SSTP_B2_LOCAL_LSB    4

// Output telegram field positions
`define SSTP_SEL_MSB         4
`define SSTP_RSV_SEL_MASK    8'he0
`define SSTP_B2_START_A_LSB  0
`define SSTP_B2_START_B_LSB  4
`define SSTP_B2_RECORDER     7
`define SSTP_RSV_B2_SINGLE   8'h7c
`define SSTP_RSV_B2_DUAL     8'h4c

// Wishbone answer latency in clock cycles after the request edge
`define SSTP_ACK_CYCLES      1

`endif

/* hdl/sstp_out_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sstp_defines.svh"

module sstp_out_decoder
	import sstp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Layout selection
	input  wire sstp_mode_e  mode_i,
	// Output telegram from the host
	input  wire sstp_otele_s otele_i,
	input  wire logic        otele_valid_i,
	// Decoded command
	output sstp_cmd_s        cmd_o,
	output logic             done_o,
	output logic             rsv_err_o
);

	sstp_dec_s st_r;
	sstp_dec_s st_nxt;

	// Decode per layout; unknown modes keep the old command
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.rsv_err = 1'b0;
		if (otele_valid_i) begin
			st_nxt.done = 1'b1;
			case (mode_i)
				SSTP_MODE_SINGLE_FP: begin
					st_nxt.cmd = '0;
					st_nxt.cmd.sel_grp1 = otele_i.byte0[`SSTP_SEL_MSB:0];
					st_nxt.cmd.start_a = otele_i.byte2[1:0];
					st_nxt.cmd.recorder = otele_i.byte2[`SSTP_B2_RECORDER];
					st_nxt.rsv_err = |(otele_i.byte0 & `SSTP_RSV_SEL_MASK)
						| (|otele_i.byte1)
						| (|(otele_i.byte2 & `SSTP_RSV_B2_SINGLE));
				end
				SSTP_MODE_SINGLE_100, SSTP_MODE_SINGLE_MULT: begin
					st_nxt.cmd = '0;
					st_nxt.cmd.sel_grp1 = otele_i.byte0[`SSTP_SEL_MSB:0];
					st_nxt.cmd.sel_grp2 = otele_i.byte1[`SSTP_SEL_MSB:0];
					st_nxt.cmd.grp2_used = 1'b1;
					st_nxt.cmd.bank_mode = (mode_i == SSTP_MODE_SINGLE_MULT);
					st_nxt.cmd.start_a = otele_i.byte2[1:0];
					st_nxt.cmd.recorder = otele_i.byte2[`SSTP_B2_RECORDER];
					st_nxt.rsv_err = |(otele_i.byte0 & `SSTP_RSV_SEL_MASK)
						| (|(otele_i.byte1 & `SSTP_RSV_SEL_MASK))
						| (|(otele_i.byte2 & `SSTP_RSV_B2_SINGLE));
				end
				SSTP_MODE_DUAL, SSTP_MODE_DUAL_FOUR, SSTP_MODE_DUAL_MULT: begin
					st_nxt.cmd = '0;
					st_nxt.cmd.sel_grp1 = otele_i.byte0[`SSTP_SEL_MSB:0];
					st_nxt.cmd.sel_grp2 = otele_i.byte1[`SSTP_SEL_MSB:0];
					st_nxt.cmd.grp2_used = 1'b1;
					st_nxt.cmd.dual = 1'b1;
					st_nxt.cmd.start_a = otele_i.byte2[1:0];
					st_nxt.cmd.start_b = otele_i.byte2[5:4];
					st_nxt.cmd.recorder = otele_i.byte2[`SSTP_B2_RECORDER];
					st_nxt.rsv_err = |(otele_i.byte0 & `SSTP_RSV_SEL_MASK)
						| (|(otele_i.byte1 & `SSTP_RSV_SEL_MASK))
						| (|(otele_i.byte2 & `SSTP_RSV_B2_DUAL));
				end
				default: begin
					st_nxt.rsv_err = 1'b1;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cmd_o     = st_r.cmd;
	assign done_o    = st_r.done;
	assign rsv_err_o = st_r.rsv_err;

endmodule
`default_nettype wire

/* hdl/sstp_packer.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Byte 0 bits 0-3: safe zone-free signals
// - Byte 0 bits 4-7: active zone status
// - Byte 1 bits 0-3: restart interlock requests
// - Byte 2 bits 0-3: collective diagnostics
// - Byte 2 bits 4-5: local output states
// - Byte 3: protocol status byte
// - Host commands fields; decode by mode
// - Single mode: select, start, recorder bits
// - Dual mode: selects A, B and starts
// - Three user bytes each direction
`include "sstp_defines.svh"

module sstp_packer
	import sstp_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Wishbone slave
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [4:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic [31:0]       wb_dat_o,
	output logic              wb_ack_o,
	// Scanner state and protocol layer inputs
	input  wire logic         cycle_strobe_i,
	input  wire sstp_scan_s   scan_i,
	input  wire logic [7:0]   ps_status_i,
	input  wire logic [23:0]  crc_i,
	// Input telegram toward the host
	output sstp_tele_s        tele_o,
	output logic              tele_valid_o,
	// Output telegram from the host
	input  wire sstp_otele_s  otele_i,
	input  wire logic         otele_valid_i,
	// Decoded command
	output sstp_cmd_s         cmd_o,
	output logic              cmd_valid_o,
	// Interrupt
	output logic              irq_o
);

	sstp_core_s st_r;
	sstp_core_s st_nxt;

	// Decoder results
	sstp_cmd_s  dec_cmd;
	logic       dec_done;
	logic       dec_rsv_err;

	// Per-bit fall of the safe zone-free signals
	logic [3:0] safe_now;
	logic [3:0] safe_fall;
	logic [3:0] irq_events;

	// Bus request qualifiers
	logic       req;
	logic       wr_commit;
	logic       rd_commit;
	logic [4:0] adr;
	logic       wr_lane0;

	// One select line per mapped register offset
	logic       hit_ctrl;
	logic       hit_tele;
	logic       hit_crc;
	logic       hit_cmd;
	logic       hit_stat;
	logic       hit_mask;

	// Read word, fresh telegram and next sticky status
	logic [31:0] rd_word;
	sstp_tele_s  tele_new;
	logic [3:0]  stat_clr;
	logic [3:0]  stat_nxt;

	// Host output telegram decode
	// three output bytes
	sstp_out_decoder u_dec (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.mode_i        (st_r.mode),
		.otele_i       (otele_i),
		.otele_valid_i (otele_valid_i),
		.cmd_o         (dec_cmd),
		.done_o        (dec_done),
		.rsv_err_o     (dec_rsv_err)
	);

	// Safe bits of the incoming sample
	assign safe_now = {scan_i.func_b_prot_zone_free_safe,
		scan_i.func_b_warn_zone_free_safe,
		scan_i.func_a_prot_zone_free_safe,
		scan_i.func_a_warn_zone_free_safe};

	// A free-to-occupied change on any safe bit raises an event
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_fall
			assign safe_fall[gi] = cycle_strobe_i & st_r.prev_safe[gi]
				& ~safe_now[gi];
		end
	endgenerate

	// Event vector in interrupt bit order
	always_comb begin
		irq_events = '0;
		irq_events[`SSTP_IRQ_TELE] = cycle_strobe_i;
		irq_events[`SSTP_IRQ_CMD] = dec_done;
		irq_events[`SSTP_IRQ_SAFE_FALL] = |safe_fall;
		irq_events[`SSTP_IRQ_RSV_ERR] = dec_rsv_err;
	end

	// Request seen, and commit at the acknowledge edge
	assign req       = wb_cyc_i & wb_stb_i;
	assign adr       = wb_adr_i;
	assign wr_commit = (st_r.bus == SSTP_BUS_ACK) & req & wb_we_i;
	assign rd_commit = (st_r.bus == SSTP_BUS_ACK) & req & ~wb_we_i;

	// Writes land through byte lane 0 at the acknowledge edge
	assign wr_lane0  = wr_commit & wb_sel_i[0];

	// Address decode; an unmapped offset selects nothing
	// Full compare, so aliases of a mapped offset read zero
	always_comb begin
		hit_ctrl = 1'b0;
		hit_tele = 1'b0;
		hit_crc  = 1'b0;
		hit_cmd  = 1'b0;
		hit_stat = 1'b0;
		hit_mask = 1'b0;
		if (adr == `SSTP_OFF_CTRL) begin
			hit_ctrl = 1'b1;
		end else if (adr == `SSTP_OFF_TELE) begin
			hit_tele = 1'b1;
		end else if (adr == `SSTP_OFF_CRC) begin
			hit_crc = 1'b1;
		end else if (adr == `SSTP_OFF_CMD) begin
			hit_cmd = 1'b1;
		end else if (adr == `SSTP_OFF_IRQ_STAT) begin
			hit_stat = 1'b1;
		end else if (adr == `SSTP_OFF_IRQ_MASK) begin
			hit_mask = 1'b1;
		end
	end

	// Read word; unmapped offsets and unused bits read zero
	// Latched at the request edge, so it stands through the ack
	always_comb begin
		rd_word = 32'h0;
		if (hit_ctrl) begin
			rd_word[`SSTP_CTRL_MODE_MSB:`SSTP_CTRL_MODE_LSB] = st_r.mode;
		end else if (hit_tele) begin
			rd_word[7:0]   = st_r.tele.byte0;
			rd_word[15:8]  = st_r.tele.byte1;
			rd_word[23:16] = st_r.tele.byte2;
			rd_word[31:24] = st_r.tele.byte3;
		end else if (hit_crc) begin
			rd_word[7:0]   = st_r.tele.crc_byte_low;
			rd_word[15:8]  = st_r.tele.crc_byte_mid;
			rd_word[23:16] = st_r.tele.crc_byte_high;
		end else if (hit_cmd) begin
			rd_word[17:0] = dec_cmd;
		end else if (hit_stat) begin
			rd_word[3:0] = st_r.irq_stat;
		end else if (hit_mask) begin
			rd_word[3:0] = st_r.irq_mask;
		end
	end

	// Telegram fields from the current sample, in wire order
	// Taken whole at the strobe edge, so no bit mixes two samples
	always_comb begin
		tele_new = '0;
		tele_new.byte0[0] = scan_i.func_a_warn_zone_free_safe;
		tele_new.byte0[1] = scan_i.func_a_prot_zone_free_safe;
		tele_new.byte0[2] = scan_i.func_b_warn_zone_free_safe;
		tele_new.byte0[3] = scan_i.func_b_prot_zone_free_safe;
		tele_new.byte0[4] = scan_i.func_a_warn_zone_state;
		tele_new.byte0[5] = scan_i.func_a_prot_zone_state;
		tele_new.byte0[6] = scan_i.func_b_warn_zone_state;
		tele_new.byte0[7] = scan_i.func_b_prot_zone_state;
		tele_new.byte1[0] = scan_i.func_a_warn_restart_request;
		tele_new.byte1[1] = scan_i.func_a_restart_request;
		tele_new.byte1[2] = scan_i.func_b_warn_restart_request;
		tele_new.byte1[3] = scan_i.func_b_restart_request;
		tele_new.byte2[0] = scan_i.error_switch_off;
		tele_new.byte2[1] = scan_i.screen_dirty;
		tele_new.byte2[2] = scan_i.pair_select_fault;
		tele_new.byte2[3] = scan_i.park_done;
		tele_new.byte2[4] = scan_i.local_out_1_state;
		tele_new.byte2[5] = scan_i.local_out_2_state;
		tele_new.byte3 = ps_status_i;
		// CRC high byte first; reserved bits stay zero
		tele_new.crc_byte_high = crc_i[23:16];
		tele_new.crc_byte_mid  = crc_i[15:8];
		tele_new.crc_byte_low  = crc_i[7:0];
	end

	// Per-bit sticky status: a read clears only the bits it returned
	// An event in the clearing cycle keeps its bit set
	genvar gs;
	generate
		for (gs = 0; gs < `SSTP_IRQ_W; gs = gs + 1) begin : g_stat
			assign stat_clr[gs] = rd_commit & hit_stat & st_r.rdat[gs];
			assign stat_nxt[gs] = irq_events[gs]
				| (st_r.irq_stat[gs] & ~stat_clr[gs]);
		end
	endgenerate

	// Next-state logic for bus, telegram and interrupts
	always_comb begin
		st_nxt = st_r;
		st_nxt.tele_vld = 1'b0;

		// Telegram assembly on each communication cycle
		if (cycle_strobe_i) begin
			st_nxt.prev_safe = safe_now;
			st_nxt.tele = tele_new;
			st_nxt.tele_vld = 1'b1;
		end

		// Bus handshake: answer one cycle after the request
		case (st_r.bus)
			SSTP_BUS_IDLE: begin
				if (req) begin
					st_nxt.bus = SSTP_BUS_ACK;
					st_nxt.rdat = rd_word;
				end
			end
			SSTP_BUS_ACK: begin
				st_nxt.bus = SSTP_BUS_IDLE;
			end
			default: begin
				st_nxt.bus = SSTP_BUS_IDLE;
			end
		endcase

		// Register writes take effect at the acknowledge edge
		// Mode codes without a layout are kept; the decoder flags them
		if (wr_lane0) begin
			if (hit_ctrl) begin
				st_nxt.mode = sstp_mode_e'(
					wb_dat_i[`SSTP_CTRL_MODE_MSB:`SSTP_CTRL_MODE_LSB]);
			end else if (hit_mask) begin
				st_nxt.irq_mask = wb_dat_i[3:0];
			end
		end

		// Read clears only the bits returned; new events win
		st_nxt.irq_stat = stat_nxt;

		// Level interrupt from unmasked sticky bits
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.bus <= SSTP_BUS_IDLE;
			st_r.mode <= sstp_mode_e'(`SSTP_CTRL_RST);
			st_r.irq_mask <= `SSTP_IRQ_MASK_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign wb_dat_o     = st_r.rdat;
	assign wb_ack_o     = (st_r.bus == SSTP_BUS_ACK) & req;
	assign tele_o       = st_r.tele;
	assign tele_valid_o = st_r.tele_vld;
	assign cmd_o        = dec_cmd;
	assign cmd_valid_o  = dec_done;
	assign irq_o        = st_r.irq;

endmodule
`default_nettype wire

/* hdl/sstp_pkg.sv */
package sstp_pkg;

	// Function modes that pick the output telegram layout
	typedef enum logic [2:0] {
		SSTP_MODE_SINGLE_FP   = 3'h0,
		SSTP_MODE_SINGLE_100  = 3'h1,
		SSTP_MODE_SINGLE_MULT = 3'h2,
		SSTP_MODE_DUAL        = 3'h3,
		SSTP_MODE_DUAL_FOUR   = 3'h4,
		SSTP_MODE_DUAL_MULT   = 3'h5
	} sstp_mode_e;

	// Wishbone slave states
	typedef enum logic {
		SSTP_BUS_IDLE = 1'b0,
		SSTP_BUS_ACK  = 1'b1
	} sstp_bus_e;

	// Scanner state sampled once per communication cycle
	typedef struct packed {
		logic func_a_warn_zone_free_safe;
		logic func_a_prot_zone_free_safe;
		logic func_b_warn_zone_free_safe;
		logic func_b_prot_zone_free_safe;
		logic func_a_warn_zone_state;
		logic func_a_prot_zone_state;
		logic func_b_warn_zone_state;
		logic func_b_prot_zone_state;
		logic func_a_warn_restart_request;
		logic func_a_restart_request;
		logic func_b_warn_restart_request;
		logic func_b_restart_request;
		logic error_switch_off;
		logic screen_dirty;
		logic pair_select_fault;
		logic park_done;
		logic local_out_1_state;
		logic local_out_2_state;
	} sstp_scan_s;

	// Input telegram, payload and CRC
	typedef struct packed {
		logic [7:0] byte0;
		logic [7:0] byte1;
		logic [7:0] byte2;
		logic [7:0] byte3;
		logic [7:0] crc_byte_high;
		logic [7:0] crc_byte_mid;
		logic [7:0] crc_byte_low;
	} sstp_tele_s;

	// Output telegram user bytes
	typedef struct packed {
		logic [7:0] byte0;
		logic [7:0] byte1;
		logic [7:0] byte2;
	} sstp_otele_s;

	// Decoded host command
	typedef struct packed {
		logic [4:0] sel_grp1;
		logic [4:0] sel_grp2;
		logic       grp2_used;
		logic       bank_mode;
		logic       dual;
		logic [1:0] start_a;
		logic [1:0] start_b;
		logic       recorder;
	} sstp_cmd_s;

	// Decoder state
	typedef struct packed {
		sstp_cmd_s cmd;
		logic      done;
		logic      rsv_err;
	} sstp_dec_s;

	// Packer state
	typedef struct packed {
		sstp_bus_e  bus;
		logic [31:0] rdat;
		sstp_tele_s tele;
		logic       tele_vld;
		logic [3:0] prev_safe;
		sstp_mode_e mode;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic       irq;
	} sstp_core_s;

endpackage

/* verification/sstp_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sstp_checker
	import sstp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Watched ports
	input  wire logic        wb_ack_o,
	input  wire logic        cycle_strobe_i,
	input  wire sstp_scan_s  scan_i,
	input  wire logic [7:0]  ps_status_i,
	input  wire logic [23:0] crc_i,
	input  wire sstp_tele_s  tele_o,
	input  wire logic        tele_valid_o,
	input  wire logic        otele_valid_i,
	input  wire logic        cmd_valid_o
);
	logic [17:0] scan_r;
	logic [7:0]  ps_r;
	logic [23:0] crc_r;
	logic [17:0] rev_s;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Inputs seen at the strobe edge, bits reversed into wire order
	always_ff @(posedge clk_i) begin
		scan_r <= scan_i;
		ps_r   <= ps_status_i;
		crc_r  <= crc_i;
	end
	assign rev_s = {<<{scan_r}};

	a_safe_nibble: assert property (
		cycle_strobe_i |=> tele_o.byte0[3:0] == rev_s[3:0])
		else $error("safe bits wrong");
	a_zone_state: assert property (
		cycle_strobe_i |=> tele_o.byte0[7:4] == rev_s[7:4])
		else $error("zone state bits wrong");
	a_restart_byte: assert property (
		cycle_strobe_i |=> tele_o.byte1 == {4'h0, rev_s[11:8]})
		else $error("restart byte wrong");
	a_diag_byte: assert property (
		cycle_strobe_i |=> tele_o.byte2 == {2'h0, rev_s[17:12]})
		else $error("diagnostic byte wrong");
	a_status_byte: assert property (
		cycle_strobe_i |=> tele_o.byte3 == ps_r)
		else $error("status byte wrong");
	a_crc_order: assert property (
		cycle_strobe_i |=> {tele_o.crc_byte_high, tele_o.crc_byte_mid,
		tele_o.crc_byte_low} == crc_r)
		else $error("crc bytes wrong");
	a_tele_valid: assert property (
		cycle_strobe_i |=> tele_valid_o)
		else $error("telegram valid missing");
	a_tele_hold: assert property (
		!cycle_strobe_i |=> $stable(tele_o) && !tele_valid_o)
		else $error("telegram changed without strobe");
	a_cmd_cause: assert property (
		!otele_valid_i |=> !cmd_valid_o)
		else $error("command valid without telegram");

	// Main scenarios
	c_bus: cover property (wb_ack_o);
	c_tele: cover property (tele_valid_o);
	c_cmd: cover property (cmd_valid_o);
endmodule

bind sstp_packer sstp_checker u_chk (
	.clk_i, .rst_i, .wb_ack_o, .cycle_strobe_i, .scan_i, .ps_status_i,
	.crc_i, .tele_o, .tele_valid_o, .otele_valid_i, .cmd_valid_o
);
`default_nettype wire

/* verification/sstp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sstp_host_model
	import sstp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Bench request
	input  wire logic        send_i,
	input  wire sstp_otele_s data_i,
	// Device telegrams
	input  wire sstp_tele_s  tele_i,
	input  wire logic        tele_valid_i,
	output sstp_otele_s      otele_o,
	output logic             otele_valid_o,
	output logic [3:0]       safe_o
);
	always_ff @(posedge clk_i) begin
		otele_valid_o <= send_i && !rst_i;
		if (rst_i) begin
			otele_o <= '0;
		end else begin
			otele_o <= send_i ? data_i : ~otele_o; // Stale bytes toggle
		end
	end
	always_ff @(posedge clk_i) begin
		if (tele_valid_i) begin
			safe_o <= tele_i.byte0[3:0];
		end
	end
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sstp_defines.svh"
module tb;
	import sstp_pkg::*;
	// Bus, telegram and host signals
	logic        clk_i          = 1'b0;
	logic        rst_i          = 1'b1;
	logic        wb_cyc_i       = 1'b0;
	logic        wb_stb_i       = 1'b0;
	logic        wb_we_i        = 1'b0;
	logic [4:0]  wb_adr_i       = 5'h00;
	logic [3:0]  wb_sel_i       = 4'hf;
	logic [31:0] wb_dat_i       = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        cycle_strobe_i = 1'b0;
	sstp_scan_s  scan_i         = '0;
	logic [7:0]  ps_status_i    = 8'h00;
	logic [23:0] crc_i          = 24'h0;
	sstp_tele_s  tele_o;
	logic        tele_valid_o;
	sstp_otele_s otele_i;
	logic        otele_valid_i;
	sstp_cmd_s   cmd_o;
	logic        cmd_valid_o;
	logic        irq_o;
	logic        send           = 1'b0;
	sstp_otele_s hdat           = '0;
	logic [3:0]  safe;
	sstp_tele_s  last;
	sstp_otele_s o;
	int          failures       = 0;
	int          n_checks       = 0;

	// Clock of 5 ns
	always #2.5 clk_i = ~clk_i;

	// Device and host controller
	sstp_packer u_dut (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cycle_strobe_i,
		.scan_i, .ps_status_i, .crc_i, .tele_o, .tele_valid_o, .otele_i,
		.otele_valid_i, .cmd_o, .cmd_valid_o, .irq_o
	);
	sstp_host_model u_host (
		.clk_i, .rst_i, .send_i(send), .data_i(hdat), .tele_i(tele_o),
		.tele_valid_i(tele_valid_o), .otele_o(otele_i),
		.otele_valid_o(otele_valid_i), .safe_o(safe)
	);

	task test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [55:0] e,
		input logic [55:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Expected telegram: fields in wire order, reserved bits zero
	function automatic sstp_tele_s exp_tele(logic [17:0] s,
		logic [7:0] p, logic [23:0] c);
		logic [17:0] v;
		v = {<<{s}};
		return {v[7:0], 4'h0, v[11:8], 2'h0, v[17:12], p, c};
	endfunction

	// Classic Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		if (wb_ack_o !== 1'b1) begin
			failures++;
			test_done();
		end else begin
			r = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask

	task automatic rd(input string nm, input logic [4:0] a,
		input logic [31:0] e, input logic [31:0] m);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		if (m !== 32'h0) chk(nm, e, r & m);
	endtask

	// One communication cycle
	task automatic tel(input logic [17:0] s, input logic [7:0] p,
		input logic [23:0] c);
		@(posedge clk_i);
		cycle_strobe_i <= 1'b1;
		scan_i         <= s;
		ps_status_i    <= p;
		crc_i          <= c;
		@(posedge clk_i);
		cycle_strobe_i <= 1'b0;
		#1;
		last = exp_tele(s, p, c);
		chk("tele", last, tele_o);
		chk("tele_valid", 1, tele_valid_o);
	endtask

	// Host output telegram, settled after decode
	task automatic host(input sstp_otele_s t);
		@(posedge clk_i);
		send <= 1'b1;
		hdat <= t;
		@(posedge clk_i);
		send <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask

	task automatic bad(input logic [2:0] m, input logic [7:0] b0);
		rd("stat", `SSTP_OFF_IRQ_STAT, 0, 0);
		wr(`SSTP_OFF_CTRL, {29'h0, m});
		host({b0, 16'h0001});
		rd("rsv_err", `SSTP_OFF_IRQ_STAT, 32'ha, '1);
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd("ctrl", `SSTP_OFF_CTRL, 0, '1);
		rd("mask", `SSTP_OFF_IRQ_MASK, 0, '1);
		rd("unmapped", 5'h18, 0, '1);
		for (int i = 0; i < 19; i++) begin
			tel(i < 18 ? 18'h1 << i : 18'h3ffff, 8'(8'h3c ^ i),
				24'(24'ha1b2c3 + i));
		end
		// The host model latches on the valid pulse, one edge later
		@(posedge clk_i);
		#1;
		chk("host_safe", 4'hf, safe);
		rd("tele_reg", `SSTP_OFF_TELE, {last.byte3, last.byte2, last.byte1,
			last.byte0}, '1);
		rd("crc_reg", `SSTP_OFF_CRC, {8'h0, last[23:0]}, '1);
		// Interrupt raised, cleared by read, then masked
		rd("stat", `SSTP_OFF_IRQ_STAT, 0, 0);
		wr(`SSTP_OFF_IRQ_MASK, 32'h4);
		rd("mask", `SSTP_OFF_IRQ_MASK, 4, '1);
		tel(18'h0, 8'h00, 24'h0);
		repeat (2) @(posedge clk_i);
		#1;
		chk("irq_set", 1, irq_o);
		rd("stat", `SSTP_OFF_IRQ_STAT, 5, '1);
		repeat (2) @(posedge clk_i);
		#1;
		chk("irq_clr", 0, irq_o);
		wr(`SSTP_OFF_IRQ_MASK, 32'h0);
		tel(18'h3ffff, 8'h5a, 24'h123456);
		tel(18'h0, 8'ha5, 24'h654321);
		repeat (2) @(posedge clk_i);
		#1;
		chk("irq_masked", 0, irq_o);
		// Command layout of every function mode
		for (int m = 0; m < 6; m++) begin
			wr(`SSTP_OFF_CTRL, 32'(m));
			o = {8'(8'h10 + m), m ? 8'(8'h0a + m) : 8'h00,
				m > 2 ? 8'hb2 : 8'h83};
			host(o);
			chk("cmd_valid", 1, cmd_valid_o);
			chk("cmd", {o.byte0[4:0], m ? o.byte1[4:0] : 5'h0,
				o.byte2[1:0], m > 2 ? o.byte2[5:4] : 2'h0, o.byte2[7]},
				{cmd_o.sel_grp1, m ? cmd_o.sel_grp2 : 5'h0, cmd_o.start_a,
				m > 2 ? cmd_o.start_b : 2'h0, cmd_o.recorder});
			rd("cmd_reg", `SSTP_OFF_CMD, {14'h0, o.byte0[4:0],
				m ? o.byte1[4:0] : 5'h0, m != 0, m == 2, m > 2, o.byte2[1:0],
				m > 2 ? o.byte2[5:4] : 2'h0, o.byte2[7]}, '1);
		end
		bad(3'h6, 8'h01);
		chk("old_cmd", 5'h15, cmd_o.sel_grp1);
		bad(3'h0, 8'h20);
		test_done();
	end
endmodule
`default_nettype wire
